// ===== hdl/lcsb_pkg.sv
// Package for the life-cycle and secure-boot block: constants and types
package lcsb_pkg;
    // OTP word map (word addresses)
    localparam int OTP_AW = 9;
    localparam logic [8:0] W_HUK_LO = 9'h000;
    localparam logic [8:0] W_MFR_FLAGS = 9'h010;
    localparam logic [8:0] W_BKP_ROOT = 9'h011;
    localparam logic [8:0] W_MAIN_ROOT = 9'h015;
    localparam logic [8:0] W_DEV_FLAGS = 9'h021;
    localparam logic [8:0] W_CFG_FLAGS = 9'h027;
    localparam logic [8:0] W_SECURE_TOP = 9'h02B;
    localparam logic [1:0] ROOT_WORDS_M1 = 2'h3;
    // Developer flag fields
    localparam int DEV_CNT_HI = 7;
    localparam int DEV_RMA_MAIN = 30;
    localparam int DEV_RMA_BKP = 31;
    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_OTP_ADDR = 8'h08;
    localparam logic [7:0] A_OTP_DATA = 8'h0C;
    localparam logic [7:0] A_IMG_INFO = 8'h10;
    // Control bits
    localparam int C_BOOT = 0;
    localparam int C_BACKUP = 1;
    localparam int C_PROV_DONE = 2;
    localparam int C_NO_AUTH = 3;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // Chain and image limits, hash widths
    localparam logic [1:0] CHAIN_MIN = 2'h2;
    localparam logic [1:0] CHAIN_MAX = 2'h3;
    localparam logic [1:0] IMG_MAX = 2'h3;
    localparam int ROOT_W = 128;
    localparam int DIG_W = 256;

    typedef enum logic [1:0] {
        LCS_MFR = 2'h0,
        LCS_DEV = 2'h1,
        LCS_SEC = 2'h2,
        LCS_RMA = 2'h3
    } lcsb_state_type;

    typedef enum logic [3:0] {
        ST_RD_MFR = 4'h0,
        ST_RD_DEV = 4'h1,
        ST_IDLE = 4'h3,
        ST_RD_ROOT = 4'h2,
        ST_CERT = 4'h6,
        ST_IMG = 4'h7,
        ST_DONE = 4'h5,
        ST_FAIL = 4'h4,
        ST_CPU_RD = 4'hC
    } lcsb_fsm_type;

    typedef struct packed {
        logic valid;
        logic last;
        logic debug;
        logic sig_ok;
        logic [DIG_W-1:0] key_digest;
        logic [ROOT_W-1:0] next_hash;
    } lcsb_cert_type;

    typedef struct packed {
        logic valid;
        logic last;
        logic [31:0] load_addr;
        logic [31:0] flash_addr;
        logic [31:0] size;
    } lcsb_image_type;

    typedef struct packed {
        logic huk_random;
        logic code_key_valid;
        logic prov_key_valid;
    } lcsb_keypol_type;
endpackage

// ===== hdl/lcsb_top.sv
// Life-cycle state decode, debug gating and certificate-chain boot control
`timescale 1ns/1ps
module lcsb_top (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic otp_req_o,
    output logic [8:0] otp_addr_o,
    input wire logic [31:0] otp_rdata_i,
    input wire logic otp_ack_i,
    input wire lcsb_pkg::lcsb_cert_type cert_i,
    input wire lcsb_pkg::lcsb_image_type image_i,
    output lcsb_pkg::lcsb_image_type load_o,
    output logic exec_en_o,
    output logic uart_en_o,
    output logic jtag_en_o,
    output logic por_req_o,
    output lcsb_pkg::lcsb_keypol_type keypol_o,
    output lcsb_pkg::lcsb_state_type life_cycle_state_o
);
    lcsb_pkg::lcsb_fsm_type state_reg, state_next;
    lcsb_pkg::lcsb_state_type lcs_reg, lcs_next;
    logic [31:0] mfr_reg;
    logic [31:0] ctrl_reg;
    logic [127:0] root_reg;
    logic [127:0] saved_reg;
    logic [1:0] word_reg;
    logic [1:0] cert_cnt_reg;
    logic [1:0] img_cnt_reg;
    logic dbg_unlock_reg;
    logic dbg_chain_reg;
    logic boot_ok_reg;
    logic boot_fail_reg;
    logic cpu_deny_reg;
    logic cpu_pend_reg;
    logic [8:0] cpu_addr_reg;
    logic [31:0] cpu_data_reg;
    logic rma_reg;

    // Decode of the two flag words, used once after reset
    wire dev_low_zero = (otp_rdata_i[lcsb_pkg::DEV_CNT_HI:0] == 8'h00);
    wire mfr_zero = (mfr_reg == 32'h0000_0000);
    wire rma_flags = otp_rdata_i[lcsb_pkg::DEV_RMA_MAIN]
                   & otp_rdata_i[lcsb_pkg::DEV_RMA_BKP];
    wire dev_zero = (otp_rdata_i == 32'h0000_0000);
    lcsb_pkg::lcsb_state_type decoded;
    always_comb begin
        if (rma_flags) begin
            decoded = lcsb_pkg::LCS_RMA;
        end else if (mfr_zero && dev_zero) begin
            decoded = lcsb_pkg::LCS_MFR;
        end else if (mfr_zero) begin
            // Developer word set on blank maker word: treat as maker state
            decoded = lcsb_pkg::LCS_MFR;
        end else if (dev_low_zero) begin
            decoded = lcsb_pkg::LCS_DEV;
        end else begin
            decoded = lcsb_pkg::LCS_SEC;
        end
    end

    // Certificate checks
    wire [127:0] key_hash = cert_i.key_digest[255:128];
    wire [127:0] expect_hash = (cert_cnt_reg == 2'h0) ? root_reg
                                                      : saved_reg;
    wire hash_ok = (key_hash == expect_hash);
    wire cert_ok = hash_ok && cert_i.sig_ok;
    wire [1:0] chain_len = cert_cnt_reg + 2'h1;
    wire len_ok = (chain_len >= lcsb_pkg::CHAIN_MIN)
               && (chain_len <= lcsb_pkg::CHAIN_MAX);
    wire too_long = (chain_len == lcsb_pkg::CHAIN_MAX) && !cert_i.last;

    // Register bus decode
    wire sel_ctrl = (addr_i == lcsb_pkg::A_CTRL);
    wire sel_stat = (addr_i == lcsb_pkg::A_STATUS);
    wire sel_oadr = (addr_i == lcsb_pkg::A_OTP_ADDR);
    wire sel_odat = (addr_i == lcsb_pkg::A_OTP_DATA);
    wire sel_img = (addr_i == lcsb_pkg::A_IMG_INFO);
    wire boot_cmd = wr_i && sel_ctrl && wdata_i[lcsb_pkg::C_BOOT];
    wire prov_cmd = wr_i && sel_ctrl && wdata_i[lcsb_pkg::C_PROV_DONE];
    wire cpu_cmd = wr_i && sel_oadr;
    wire cpu_prot = (wdata_i[8:0] <= lcsb_pkg::W_SECURE_TOP);
    // Bypass only outside secure state; secure always authenticates
    wire no_auth = ctrl_reg[lcsb_pkg::C_NO_AUTH]
                && (lcs_reg != lcsb_pkg::LCS_SEC);
    wire [8:0] root_base = ctrl_reg[lcsb_pkg::C_BACKUP]
                         ? lcsb_pkg::W_BKP_ROOT : lcsb_pkg::W_MAIN_ROOT;
    wire [31:0] status_word = {20'h0, cpu_deny_reg, dbg_unlock_reg,
                               boot_fail_reg, boot_ok_reg,
                               state_reg, 2'h0, lcs_reg};
    logic [31:0] rd_mux;
    always_comb begin
        if (sel_ctrl) begin
            rd_mux = ctrl_reg;
        end else if (sel_stat) begin
            rd_mux = status_word;
        end else if (sel_oadr) begin
            rd_mux = {23'h0, cpu_addr_reg};
        end else if (sel_odat) begin
            rd_mux = cpu_data_reg;
        end else if (sel_img) begin
            rd_mux = {28'h0, cert_cnt_reg, img_cnt_reg};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    // Sequencer
    always_comb begin
        state_next = state_reg;
        lcs_next = lcs_reg;
        case (state_reg)
            lcsb_pkg::ST_RD_MFR: begin
                if (otp_ack_i) begin
                    state_next = lcsb_pkg::ST_RD_DEV;
                end
            end
            lcsb_pkg::ST_RD_DEV: begin
                if (otp_ack_i) begin
                    lcs_next = decoded;
                    state_next = lcsb_pkg::ST_IDLE;
                end
            end
            lcsb_pkg::ST_IDLE: begin
                if (boot_cmd && no_auth) begin
                    state_next = lcsb_pkg::ST_IMG;
                end else if (boot_cmd) begin
                    state_next = lcsb_pkg::ST_RD_ROOT;
                end else if (cpu_pend_reg) begin
                    state_next = lcsb_pkg::ST_CPU_RD;
                end
            end
            lcsb_pkg::ST_CPU_RD: begin
                if (otp_ack_i) begin
                    state_next = lcsb_pkg::ST_IDLE;
                end
            end
            lcsb_pkg::ST_RD_ROOT: begin
                if (otp_ack_i && word_reg == lcsb_pkg::ROOT_WORDS_M1) begin
                    state_next = lcsb_pkg::ST_CERT;
                end
            end
            lcsb_pkg::ST_CERT: begin
                if (cert_i.valid) begin
                    if (!cert_ok || too_long
                        || (cert_i.last && !len_ok)) begin
                        state_next = lcsb_pkg::ST_FAIL;
                    end else if (cert_i.last && dbg_chain_reg) begin
                        state_next = lcsb_pkg::ST_DONE;
                    end else if (cert_i.last) begin
                        state_next = lcsb_pkg::ST_IMG;
                    end
                end
            end
            lcsb_pkg::ST_IMG: begin
                if (image_i.valid && image_i.last) begin
                    state_next = lcsb_pkg::ST_DONE;
                end else if (image_i.valid
                             && img_cnt_reg == lcsb_pkg::IMG_MAX) begin
                    state_next = lcsb_pkg::ST_FAIL;
                end
            end
            lcsb_pkg::ST_DONE: begin
                if (boot_cmd) begin
                    state_next = lcsb_pkg::ST_RD_ROOT;
                end
            end
            lcsb_pkg::ST_FAIL: begin
                if (boot_cmd) begin
                    state_next = lcsb_pkg::ST_RD_ROOT;
                end
            end
            default: begin
                state_next = lcsb_pkg::ST_RD_MFR;
            end
        endcase
    end

    // OTP address for the next cycle
    logic [8:0] otp_addr_next;
    logic otp_req_next;
    always_comb begin
        otp_req_next = 1'b0;
        otp_addr_next = otp_addr_o;
        case (state_next)
            lcsb_pkg::ST_RD_MFR: begin
                otp_req_next = 1'b1;
                otp_addr_next = lcsb_pkg::W_MFR_FLAGS;
            end
            lcsb_pkg::ST_RD_DEV: begin
                otp_req_next = 1'b1;
                otp_addr_next = lcsb_pkg::W_DEV_FLAGS;
            end
            lcsb_pkg::ST_RD_ROOT: begin
                otp_req_next = 1'b1;
                if (state_reg != lcsb_pkg::ST_RD_ROOT) begin
                    otp_addr_next = root_base;
                end else if (otp_ack_i) begin
                    otp_addr_next = otp_addr_o + 9'h001;
                end
            end
            lcsb_pkg::ST_CPU_RD: begin
                otp_req_next = 1'b1;
                otp_addr_next = cpu_addr_reg;
            end
            default: begin
                otp_req_next = 1'b0;
            end
        endcase
        if (otp_ack_i && state_reg != state_next) begin
            otp_req_next = otp_req_next && (state_next
                           != lcsb_pkg::ST_IDLE);
        end
    end

    // State, decode and OTP port
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= lcsb_pkg::ST_RD_MFR;
            lcs_reg <= lcsb_pkg::LCS_MFR;
            otp_req_o <= 1'b1;
            otp_addr_o <= lcsb_pkg::W_MFR_FLAGS;
            mfr_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            lcs_reg <= lcs_next;
            otp_req_o <= otp_req_next;
            otp_addr_o <= otp_addr_next;
            if (state_reg == lcsb_pkg::ST_RD_MFR && otp_ack_i) begin
                mfr_reg <= otp_rdata_i;
            end
        end
    end

    // Root hash, chain walk and debug unlock
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            root_reg <= 128'h0;
            saved_reg <= 128'h0;
            word_reg <= 2'h0;
            cert_cnt_reg <= 2'h0;
            dbg_chain_reg <= 1'b0;
            dbg_unlock_reg <= 1'b0;
        end else begin
            if (state_next == lcsb_pkg::ST_RD_ROOT
                && state_reg != lcsb_pkg::ST_RD_ROOT) begin
                word_reg <= 2'h0;
                cert_cnt_reg <= 2'h0;
                dbg_chain_reg <= 1'b0;
            end else if (state_reg == lcsb_pkg::ST_RD_ROOT
                         && otp_ack_i) begin
                root_reg <= {otp_rdata_i, root_reg[127:32]};
                word_reg <= word_reg + 2'h1;
            end
            if (state_reg == lcsb_pkg::ST_CERT && cert_i.valid
                && cert_ok) begin
                if (!cert_i.last) begin
                    saved_reg <= cert_i.next_hash;
                    cert_cnt_reg <= chain_len;
                end
                if (cert_i.debug) begin
                    dbg_chain_reg <= 1'b1;
                end
                // Unlock only from a fully verified debug chain
                if (cert_i.last && len_ok && (cert_i.debug
                    || dbg_chain_reg)) begin
                    dbg_unlock_reg <= 1'b1;
                end
            end
        end
    end

    // Image walk and boot result
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            img_cnt_reg <= 2'h0;
            load_o <= '0;
            boot_ok_reg <= 1'b0;
            boot_fail_reg <= 1'b0;
            exec_en_o <= 1'b0;
        end else begin
            load_o.valid <= 1'b0;
            if (boot_cmd) begin
                img_cnt_reg <= 2'h0;
                boot_ok_reg <= 1'b0;
                boot_fail_reg <= 1'b0;
                exec_en_o <= 1'b0;
            end else if (state_reg == lcsb_pkg::ST_IMG && image_i.valid
                         && img_cnt_reg != lcsb_pkg::IMG_MAX) begin
                load_o <= image_i;
                img_cnt_reg <= img_cnt_reg + 2'h1;
            end
            if (state_next == lcsb_pkg::ST_FAIL
                && state_reg != lcsb_pkg::ST_FAIL) begin
                boot_fail_reg <= 1'b1;
                exec_en_o <= 1'b0;
            end
            if (state_next == lcsb_pkg::ST_DONE
                && state_reg != lcsb_pkg::ST_DONE) begin
                boot_ok_reg <= 1'b1;
                // A chain with debug set before its last certificate loads no image, so nothing may run
                exec_en_o <= (state_reg == lcsb_pkg::ST_IMG);
            end
        end
    end

    // Software registers and the processor OTP window
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_reg <= lcsb_pkg::CTRL_RST;
            cpu_addr_reg <= 9'h000;
            cpu_data_reg <= 32'h0000_0000;
            cpu_deny_reg <= 1'b0;
            cpu_pend_reg <= 1'b0;
            rdata_o <= 32'h0000_0000;
            por_req_o <= 1'b0;
        end else begin
            rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
            if (wr_i && sel_ctrl) begin
                ctrl_reg <= {wdata_i[31:3], 1'b0, wdata_i[1], 1'b0};
            end
            if (cpu_cmd) begin
                cpu_addr_reg <= wdata_i[8:0];
                cpu_deny_reg <= cpu_prot;
                cpu_pend_reg <= !cpu_prot;
                if (cpu_prot) begin
                    cpu_data_reg <= 32'h0000_0000;
                end
            end else if (state_reg == lcsb_pkg::ST_CPU_RD
                         && otp_ack_i) begin
                cpu_data_reg <= otp_rdata_i;
                cpu_pend_reg <= 1'b0;
            end
            // Reset request after provisioning; the system re-decodes
            por_req_o <= prov_cmd && (lcs_reg == lcsb_pkg::LCS_MFR
                        || lcs_reg == lcsb_pkg::LCS_DEV);
        end
    end

    // Debug gating and key policy from the decoded state; secure state opens debug on unlock
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            uart_en_o <= 1'b0;
            jtag_en_o <= 1'b0;
            keypol_o <= '0;
            life_cycle_state_o <= lcsb_pkg::LCS_MFR;
            rma_reg <= 1'b0;
        end else begin
            life_cycle_state_o <= lcs_reg;
            rma_reg <= (lcs_reg == lcsb_pkg::LCS_RMA);
            case (lcs_reg)
                lcsb_pkg::LCS_MFR, lcsb_pkg::LCS_DEV: begin
                    uart_en_o <= (state_reg != lcsb_pkg::ST_RD_MFR)
                              && (state_reg != lcsb_pkg::ST_RD_DEV);
                    jtag_en_o <= (state_reg != lcsb_pkg::ST_RD_MFR)
                              && (state_reg != lcsb_pkg::ST_RD_DEV);
                end
                lcsb_pkg::LCS_SEC: begin
                    uart_en_o <= dbg_unlock_reg;
                    jtag_en_o <= dbg_unlock_reg;
                end
                default: begin
                    uart_en_o <= 1'b1;
                    jtag_en_o <= 1'b1;
                end
            endcase
            // Key engine draws a fresh random unique key when set
            keypol_o.huk_random <= rma_reg;
            keypol_o.code_key_valid <= !rma_reg;
            keypol_o.prov_key_valid <= !rma_reg;
        end
    end
endmodule // lcsb_top

// ===== test/lcsb_sva.sv
// Assertion checker for the life-cycle and secure-boot block
`timescale 1ns/1ps
module lcsb_sva (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic otp_req_o,
    input wire logic [8:0] otp_addr_o,
    input wire logic [31:0] otp_rdata_i,
    input wire logic otp_ack_i,
    input wire lcsb_pkg::lcsb_cert_type cert_i,
    input wire lcsb_pkg::lcsb_image_type image_i,
    input wire lcsb_pkg::lcsb_image_type load_o,
    input wire logic exec_en_o,
    input wire logic uart_en_o,
    input wire logic jtag_en_o,
    input wire logic por_req_o,
    input wire lcsb_pkg::lcsb_keypol_type keypol_o,
    input wire lcsb_pkg::lcsb_state_type life_cycle_state_o
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    // State output trails the fall of the OTP request by one cycle
    a_open_debug_on: assert property (
        $fell(otp_req_o) ##1 life_cycle_state_o inside {lcsb_pkg::LCS_MFR,
        lcsb_pkg::LCS_DEV} |-> uart_en_o && jtag_en_o) else $error("debug off");
    a_rma_debug_on: assert property (
        life_cycle_state_o == lcsb_pkg::LCS_RMA |=> uart_en_o && jtag_en_o)
        else $error("returned state debug off");
    a_rma_key_policy: assert property (
        life_cycle_state_o == lcsb_pkg::LCS_RMA |=> keypol_o.huk_random &&
        !keypol_o.code_key_valid && !keypol_o.prov_key_valid)
        else $error("returned state key policy wrong");
    a_secure_unlock_cause: assert property (
        $rose(jtag_en_o) && life_cycle_state_o == lcsb_pkg::LCS_SEC |->
        $past(cert_i.valid && cert_i.last) ||
        $past(cert_i.valid && cert_i.last, 2)) else $error("unlock uncaused");
    a_state_held: assert property (
        life_cycle_state_o != lcsb_pkg::LCS_MFR |=> $stable(life_cycle_state_o))
        else $error("state changed without reset");
    a_load_copy: assert property (
        load_o.valid |-> $past(image_i.valid) &&
        load_o.load_addr == $past(image_i.load_addr) &&
        load_o.size == $past(image_i.size)) else $error("load fields wrong");
    a_exec_after_last: assert property (
        $rose(exec_en_o) |-> $past(image_i.valid && image_i.last))
        else $error("exec without last image");
    a_fail_no_exec: assert property (
        !exec_en_o && cert_i.valid && !cert_i.sig_ok |=> !exec_en_o [*4])
        else $error("exec after failed signature");
    a_por_single: assert property (
        por_req_o |=> !por_req_o) else $error("reset request too long");
    a_por_open_state: assert property (
        por_req_o |-> life_cycle_state_o inside {lcsb_pkg::LCS_MFR,
        lcsb_pkg::LCS_DEV}) else $error("reset request in closed state");
endmodule // lcsb_sva
bind lcsb_top lcsb_sva lcsb_sva_i (.*);

// ===== test/lcsb_otp_model.sv
// Behavioural OTP memory answering the block's word reads
`timescale 1ns/1ps
module lcsb_otp_model (
    input wire logic ref_clk_i,
    input wire logic req_i,
    input wire logic [8:0] addr_i,
    output logic [31:0] rdata_o,
    output logic ack_o
);
    logic [31:0] mem [0:511];
    logic [1:0] wait_reg;
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = 32'h0;
        end
        rdata_o = 32'h0;
        ack_o = 1'b0;
        wait_reg = 2'h0;
    end
    // Odd words answer slowly, even words at once
    always @(posedge ref_clk_i) begin
        ack_o <= 1'b0;
        // Data is not held past the ack cycle, so stale reads show up
        rdata_o <= {rdata_o[30:0], ~rdata_o[31]};
        if (req_i && !ack_o) begin
            if (wait_reg == {addr_i[0], 1'b0}) begin
                ack_o <= 1'b1;
                rdata_o <= mem[addr_i];
                wait_reg <= 2'h0;
            end else begin
                wait_reg <= wait_reg + 2'h1;
            end
        end
    end
endmodule // lcsb_otp_model

// ===== test/lcsb_top_tb.sv
// Self-checking testbench for the life-cycle and secure-boot block
`timescale 1ns/1ps
module lcsb_top_tb;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o, otp_rdata_i, st, rv;
    logic otp_req_o, otp_ack_i, exec_en_o, uart_en_o, jtag_en_o, por_req_o;
    logic [8:0] otp_addr_o;
    logic [127:0] h;
    lcsb_pkg::lcsb_cert_type cert_i = '0;
    lcsb_pkg::lcsb_image_type image_i = '0;
    lcsb_pkg::lcsb_image_type load_o;
    lcsb_pkg::lcsb_keypol_type keypol_o;
    lcsb_pkg::lcsb_state_type life_cycle_state_o;
    int err_count = 0;
    int compares = 0;
    int seed = 44;
    int cycles = 0;
    lcsb_top lcsb_top_i (.*);
    lcsb_otp_model lcsb_otp_model_i (.ref_clk_i(ref_clk_i), .req_i(otp_req_o),
        .addr_i(otp_addr_o), .rdata_o(otp_rdata_i), .ack_o(otp_ack_i));
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // A whole run needs several hundred cycles; a hang ends it here
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    task automatic wait_fsm(input logic [3:0] f);
        for (int i = 0; i < 100; i++) begin
            reg_rd(lcsb_pkg::A_STATUS, st);
            if (st[7:4] === f) return;
        end
        chk({28'h0, st[7:4]}, {28'h0, f});
    endtask
    task automatic reset_dut(input logic [31:0] m, input logic [31:0] d);
        lcsb_otp_model_i.mem[lcsb_pkg::W_MFR_FLAGS] = m;
        lcsb_otp_model_i.mem[lcsb_pkg::W_DEV_FLAGS] = d;
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        wait_fsm(4'h3);
        repeat (2) @(posedge ref_clk_i);
    endtask
    task automatic chk_state(input logic [1:0] s, input logic dbg);
        reg_rd(lcsb_pkg::A_STATUS, st);
        chk({28'h0, st[1:0], life_cycle_state_o}, {28'h0, s, s});
        chk({30'h0, uart_en_o, jtag_en_o}, {30'h0, dbg, dbg});
    endtask
    // Exec is a level, so one extra edge covers either landing cycle
    task automatic chk_exec(input logic e);
        @(posedge ref_clk_i);
        #1;
        chk({31'h0, exec_en_o}, {31'h0, e});
    endtask
    // Secure part, boot with a chain of n; bad 1 spoils hash, 2 signature
    task automatic run_chain(input logic [31:0] ctl, input int n,
        input logic dbg, input int bad);
        logic [8:0] b;
        logic [127:0] nh;
        reset_dut(32'h1, 32'h0000_00A5);
        chk_state(2'h2, 1'b0);
        b = ctl[1] ? lcsb_pkg::W_BKP_ROOT : lcsb_pkg::W_MAIN_ROOT;
        for (int i = 0; i < 4; i++) begin
            h[32*i +: 32] = lcsb_otp_model_i.mem[b + 9'(i)];
        end
        // Mode bits are taken from the register, so they go in a write ahead
        reg_wr(lcsb_pkg::A_CTRL, ctl & 32'hFFFF_FFFE);
        reg_wr(lcsb_pkg::A_CTRL, ctl);
        wait_fsm(4'h6);
        for (int i = 0; i < n; i++) begin
            nh = {$random(seed), $random(seed), $random(seed), $random(seed)};
            @(posedge ref_clk_i);
            cert_i <= {1'b1, i == n - 1, dbg, bad != 2, bad == 1 ? ~h : h,
                ~nh, nh};
            @(posedge ref_clk_i);
            cert_i.valid <= 1'b0;
            h = nh;
        end
    endtask
    task automatic run_imgs(input int n, input logic fin);
        lcsb_pkg::lcsb_image_type im;
        for (int i = 0; i < n; i++) begin
            im = {1'b1, fin && i == n - 1, $random(seed), $random(seed),
                $random(seed)};
            @(posedge ref_clk_i);
            image_i <= im;
            @(posedge ref_clk_i);
            image_i.valid <= 1'b0;
            #1;
            chk({31'h0, load_o.valid}, {31'h0, i < 3});
            if (i < 3) begin
                chk(load_o.load_addr, im.load_addr);
                chk(load_o.flash_addr, im.flash_addr);
                chk(load_o.size, im.size);
            end
        end
    endtask
    initial begin
        for (int i = 17; i < 25; i++) begin
            lcsb_otp_model_i.mem[i] = $random(seed);
        end
        lcsb_otp_model_i.mem[64] = $random(seed);
        reset_dut(32'h0, 32'h0);
        chk_state(2'h0, 1'b1);
        reg_wr(lcsb_pkg::A_OTP_ADDR, 32'h40);
        wait_fsm(4'h3);
        reg_rd(lcsb_pkg::A_OTP_DATA, rv);
        chk(rv, lcsb_otp_model_i.mem[64]);
        // Denied read must also wipe the word left by the open read
        reg_wr(lcsb_pkg::A_OTP_ADDR, {23'h0, lcsb_pkg::W_SECURE_TOP});
        reg_rd(lcsb_pkg::A_OTP_DATA, rv);
        chk(rv, 32'h0);
        reg_rd(lcsb_pkg::A_STATUS, st);
        chk({31'h0, st[11]}, 32'h1);
        reg_rd(8'h3C, rv);
        chk(rv, 32'h0);
        reg_wr(lcsb_pkg::A_CTRL, 32'h4);
        chk({31'h0, por_req_o}, 32'h1);
        reset_dut($random(seed) | 32'h1, $random(seed) & 32'h3FFF_FF00);
        chk_state(2'h1, 1'b1);
        reg_wr(lcsb_pkg::A_CTRL, 32'h4);
        chk({31'h0, por_req_o}, 32'h1);
        reg_wr(lcsb_pkg::A_CTRL, 32'h8);
        reg_wr(lcsb_pkg::A_CTRL, 32'h9);
        wait_fsm(4'h7);
        run_imgs(1, 1'b1);
        chk_exec(1'b1);
        run_chain(32'h9, 3, 1'b0, 0);
        wait_fsm(4'h7);
        run_imgs(3, 1'b1);
        reg_rd(lcsb_pkg::A_IMG_INFO, rv);
        chk({30'h0, rv[1:0]}, 32'h3);
        chk_exec(1'b1);
        run_chain(32'h3, 2, 1'b0, 1);
        wait_fsm(4'h4);
        chk({30'h0, st[9], jtag_en_o}, 32'h2);
        chk_exec(1'b0);
        run_chain(32'h1, 2, 1'b0, 2);
        wait_fsm(4'h4);
        chk_exec(1'b0);
        run_chain(32'h1, 2, 1'b1, 0);
        wait_fsm(4'h5);
        chk_state(2'h2, 1'b1);
        run_chain(32'h3, 2, 1'b0, 0);
        wait_fsm(4'h7);
        run_imgs(4, 1'b0);
        wait_fsm(4'h4);
        reset_dut(32'h1, 32'h8000_0011);
        chk_state(2'h2, 1'b0);
        reset_dut(32'h1, 32'hC000_0011);
        chk_state(2'h3, 1'b1);
        chk({29'h0, keypol_o}, 32'h4);
        end_of_test();
    end
endmodule // lcsb_top_tb
